// File: core/ppr_remap.sv
// Peripheral pin remapping matrix between pads and digital peripherals.
// Overview of operation
// - Matrix serves up to 26 remappable pins, numbered 0 to 25.
// - A remapped output overrides the parallel port and port data on its pin.
// - Special fixed outputs beat any remapped output on the same pin.
// - Mapping an input never takes drive of the pin.
// - Without remapped output, enable follows direction bit or fixed peripheral.
// - Inputs see the pin only in digital mode, inactive when analog enabled.
// - Each peripheral input has a 5-bit field; value n selects pin n.
// - Each input map register holds two fields for two inputs.
// - Valid input field values span exactly the implemented pins.
// - Input and output maps are separate register sets.
// - Remappable peripherals start disconnected from every pin.
// - Remappable set covers serial, timer, capture, compare, interrupt, comparator.
// - I2C, change notify, alarm and analog functions stay outside.
// - With one-way fuse, a set lock cannot be cleared.
// - While locked, map writes are ignored; with one-way fuse, unlock has no effect.
// - With one-way fuse, only reset clears the lock.
// - Unprogrammed fuse reads as set, one write session per reset.
// - Programmed fuse allows clearing lock through the unlock sequence.
// - Reset loads input fields with ones, output fields with zeros.
// - Map registers change only while the lock bit is zero.
// - Lock bit resets unlocked.
`timescale 1ns/1ns
`include "ppr_remap_map.svh"
module ppr_remap (
    // Clock and reset.
    input  logic                         sys_clk,
    input  logic                         resetn,
    // Mapping register write and read-back.
    input  ppr_pkg::ppr_map_wr_t         map_wr,
    input  logic                         map_rd_is_out,
    input  logic [3:0]                   map_rd_index,
    output logic [15:0]                  map_rd_data,
    // Lock control and status.
    input  ppr_pkg::ppr_lock_req_t       lock_req,
    input  logic [15:0]                  config_word_two,
    output logic                         map_write_lock,
    output logic                         single_session_lock_fuse,
    // Pad side.
    input  logic [`PPR_NUM_PINS-1:0]     pad_in,
    input  logic [`PPR_NUM_PINS-1:0]     pin_direction_bit,
    input  logic [`PPR_NUM_PINS-1:0]     port_out,
    input  logic [`PPR_NUM_PINS-1:0]     fixed_oe,
    input  logic [`PPR_NUM_PINS-1:0]     fixed_out,
    input  logic [`PPR_NUM_PINS-1:0]     special_oe,
    input  logic [`PPR_NUM_PINS-1:0]     special_out,
    input  logic [`PPR_NUM_PINS-1:0]     analog_en,
    output logic [`PPR_NUM_PINS-1:0]     pad_out,
    output logic [`PPR_NUM_PINS-1:0]     pad_oe,
    // Peripheral side; output code 0 is unused.
    input  logic [`PPR_NUM_OUT_FN-1:0]   periph_out,
    output logic [`PPR_NUM_IN_FN-1:0]    periph_in
);
    // Only digital serial, timer, capture, compare, interrupt and comparator
    // signals are wired to these ports at chip level; I2C, change notify,
    // alarm and analog functions keep their own fixed pads.
    ppr_pkg::ppr_sel_t           in_sel      [`PPR_NUM_IN_FN];
    ppr_pkg::ppr_sel_t           next_in_sel [`PPR_NUM_IN_FN];
    ppr_pkg::ppr_sel_t           out_sel     [`PPR_NUM_PINS];
    ppr_pkg::ppr_sel_t           next_out_sel[`PPR_NUM_PINS];
    logic [15:0]                 next_rd_data;
    logic [`PPR_NUM_PINS-1:0]    next_pad_out;
    logic [`PPR_NUM_PINS-1:0]    next_pad_oe;
    logic [`PPR_NUM_IN_FN-1:0]   next_periph_in;
    logic                        map_change;

    // Pin level seen by a peripheral input for a given selection.
    function automatic logic pin_level(input ppr_pkg::ppr_sel_t s,
                                       input logic [`PPR_NUM_PINS-1:0] lvl,
                                       input logic [`PPR_NUM_PINS-1:0] ana);
        logic r;
        r = `PPR_INACTIVE_LVL;
        if (s < 5'(`PPR_NUM_PINS)) begin
            r = ana[s] ? `PPR_INACTIVE_LVL : lvl[s];
        end
        return r;
    endfunction : pin_level

    // Pull one 5-bit field out of a 16-bit register image.
    function automatic ppr_pkg::ppr_sel_t field(input logic [15:0] d, input logic hi);
        return hi ? d[`PPR_FLD_HI_POS +: `PPR_SEL_W] : d[`PPR_FLD_LO_POS +: `PPR_SEL_W];
    endfunction : field

    // Pack two fields into a register image; unused bits read zero.
    function automatic logic [15:0] pack(input ppr_pkg::ppr_sel_t lo, input ppr_pkg::ppr_sel_t hi);
        return {3'h0, hi, 3'h0, lo};
    endfunction : pack

    ppr_key_lock u_lock (
        .sys_clk                  (sys_clk),
        .resetn                   (resetn),
        .lock_req                 (lock_req),
        .config_word_two          (config_word_two),
        .map_write_lock           (map_write_lock),
        .single_session_lock_fuse (single_session_lock_fuse),
        .unlock_open              ()
    );

    // Map register writes; input and output maps are separate banks.
    always_comb begin
        next_in_sel  = in_sel;
        next_out_sel = out_sel;
        if (map_wr.wr && !map_write_lock) begin
            if (!map_wr.is_out) begin
                for (int r = 0; r < `PPR_NUM_IN_REGS; r++) begin
                    if (map_wr.index == 4'(r)) begin
                        next_in_sel[2*r]   = field(map_wr.data, 1'b0);
                        next_in_sel[2*r+1] = field(map_wr.data, 1'b1);
                    end
                end
            end else begin
                for (int r = 0; r < `PPR_NUM_OUT_REGS; r++) begin
                    if (map_wr.index == 4'(r)) begin
                        next_out_sel[2*r]   = field(map_wr.data, 1'b0);
                        next_out_sel[2*r+1] = field(map_wr.data, 1'b1);
                    end
                end
            end
        end
    end

    // Read-back of the addressed register; out-of-range indices read zero.
    always_comb begin
        next_rd_data = 16'h0000;
        if (!map_rd_is_out) begin
            for (int r = 0; r < `PPR_NUM_IN_REGS; r++) begin
                if (map_rd_index == 4'(r)) begin
                    next_rd_data = pack(in_sel[2*r], in_sel[2*r+1]);
                end
            end
        end else begin
            for (int r = 0; r < `PPR_NUM_OUT_REGS; r++) begin
                if (map_rd_index == 4'(r)) begin
                    next_rd_data = pack(out_sel[2*r], out_sel[2*r+1]);
                end
            end
        end
    end

    // Pad drive with priority special, then remapped, then fixed or port.
    always_comb begin
        next_pad_out = '0;
        next_pad_oe  = '0;
        for (int p = 0; p < `PPR_NUM_PINS; p++) begin
            if (special_oe[p]) begin
                next_pad_oe[p]  = 1'b1;
                next_pad_out[p] = special_out[p];
            end else if (out_sel[p] != `PPR_OUT_NONE) begin
                next_pad_oe[p]  = 1'b1;
                next_pad_out[p] = periph_out[out_sel[p]];
            end else begin
                // Input selections never reach this term, so an input mapping
                // cannot turn a pad into a driver.
                next_pad_oe[p]  = fixed_oe[p] | ~pin_direction_bit[p];
                next_pad_out[p] = fixed_oe[p] ? fixed_out[p] : port_out[p];
            end
        end
    end

    // Peripheral inputs sample their selected pin.
    always_comb begin
        next_periph_in = '0;
        for (int f = 0; f < `PPR_NUM_IN_FN; f++) begin
            next_periph_in[f] = pin_level(in_sel[f], pad_in, analog_en);
        end
    end

    // Registering the pads costs one cycle of latency but keeps glitches
    // from the select mux off the pins.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            for (int f = 0; f < `PPR_NUM_IN_FN; f++) begin
                in_sel[f] <= `PPR_IN_SEL_RST;
            end
            for (int p = 0; p < `PPR_NUM_PINS; p++) begin
                out_sel[p] <= `PPR_OUT_SEL_RST;
            end
            map_rd_data <= 16'h0000;
            pad_out     <= '0;
            pad_oe      <= '0;
            periph_in   <= '0;
        end else begin
            in_sel      <= next_in_sel;
            out_sel     <= next_out_sel;
            map_rd_data <= next_rd_data;
            pad_out     <= next_pad_out;
            pad_oe      <= next_pad_oe;
            periph_in   <= next_periph_in;
        end
    end

    // Assertion helpers.
    assign map_change = (next_in_sel != in_sel) || (next_out_sel != out_sel);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_locked_write;
        map_write_lock && map_wr.wr;
    endsequence

    // Antecedents carry resetn so that an attempt on the release edge, where reset
    // is still sampled low while the disable already reads high, is not judged.
    sequence s_in_write0;
        resetn && map_wr.wr && !map_write_lock && !map_wr.is_out && map_wr.index == 4'h0;
    endsequence

    a_lock_freezes_map: assert property (s_locked_write |-> !map_change)
        else $error("Map changed while locked.");
    a_map_only_unlocked: assert property (map_change |-> !map_write_lock)
        else $error("Map changed with lock set.");
    a_reset_values: assert property (@(posedge sys_clk) disable iff (1'b0)
        !resetn |=> in_sel[0] == 5'h1f && in_sel[27] == 5'h1f && out_sel[0] == 5'h00 && pad_oe == '0)
        else $error("Reset values wrong.");
    a_special_wins: assert property (resetn && special_oe[0]
        |=> pad_oe[0] && pad_out[0] == $past(special_out[0]))
        else $error("Special output lost priority.");
    a_remap_wins: assert property (resetn && !special_oe[1] && out_sel[1] != 5'h00 && !fixed_oe[1]
        |=> pad_oe[1] && pad_out[1] == $past(periph_out[out_sel[1]]))
        else $error("Remapped output did not drive pin.");
    a_no_remap_dir: assert property (resetn && !special_oe[1] && out_sel[1] == 5'h00
        |=> pad_oe[1] == ($past(fixed_oe[1]) || !$past(pin_direction_bit[1])))
        else $error("Pin enable ignores direction bit.");
    a_analog_blocks: assert property (resetn && in_sel[0] < 5'd26 && analog_en[in_sel[0]]
        |=> periph_in[0] == 1'b0)
        else $error("Analog pin reached peripheral input.");
    a_null_pin: assert property (resetn && in_sel[3] >= 5'd26 |=> periph_in[3] == 1'b0)
        else $error("Missing pin not inactive.");
    a_digital_pass: assert property (resetn && in_sel[0] < 5'd26 && !analog_en[in_sel[0]]
        |=> periph_in[0] == $past(pad_in[in_sel[0]]))
        else $error("Selected pin level not delivered.");
    a_write_lands: assert property (s_in_write0
        |=> (in_sel[0] == $past(map_wr.data[4:0]) && in_sel[1] == $past(map_wr.data[12:8]))
            ##1 ($past(map_rd_is_out) || $past(map_rd_index) != 4'h0
                 || map_rd_data == ($past(map_wr.data, 2) & 16'h1f1f)))
        else $error("Input map write not stored.");
endmodule : ppr_remap

// File: core/ppr_remap_map.svh
// Constants for the peripheral pin remapping matrix.
`ifndef PPR_REMAP_MAP_SVH
`define PPR_REMAP_MAP_SVH
`define PPR_NUM_PINS      26
`define PPR_NUM_IN_FN     28
`define PPR_NUM_OUT_FN    32
`define PPR_NUM_IN_REGS   14
`define PPR_NUM_OUT_REGS  13
`define PPR_SEL_W         5
`define PPR_FLD_LO_POS    0
`define PPR_FLD_HI_POS    8
`define PPR_IN_SEL_RST    5'h1f
`define PPR_OUT_SEL_RST   5'h00
`define PPR_OUT_NONE      5'h00
`define PPR_LOCK_BIT      6
`define PPR_ONE_WAY_BIT   4
`define PPR_LOCK_RST      1'b0
`define PPR_FUSE_RST      1'b1
`define PPR_KEY_ONE       8'h5a
`define PPR_KEY_TWO       8'ha5
`define PPR_UNLOCK_WIN    3'h2
`define PPR_INACTIVE_LVL  1'b0
`endif

// File: core/ppr_pkg.sv
// Types shared by the pin remapping matrix and its lock controller.
`include "ppr_remap_map.svh"
package ppr_pkg;
    typedef logic [`PPR_SEL_W-1:0] ppr_sel_t;

    typedef struct packed {
        logic        wr;
        logic        is_out;
        logic [3:0]  index;
        logic [15:0] data;
    } ppr_map_wr_t;

    typedef struct packed {
        logic       osc_wr;
        logic [7:0] osc_data;
        logic       key_wr;
        logic [7:0] key_data;
    } ppr_lock_req_t;

    typedef enum logic [2:0] {
        KS_IDLE  = 3'b001,
        KS_ARMED = 3'b010,
        KS_OPEN  = 3'b100
    } ppr_key_state_t;
endpackage : ppr_pkg

// File: core/ppr_key_lock.sv
// Write lock of the mapping registers with key sequence and one-way fuse.
`timescale 1ns/1ns
`include "ppr_remap_map.svh"
module ppr_key_lock (
    // Clock and reset.
    input  logic                   sys_clk,
    input  logic                   resetn,
    // Lock control writes and fuse word.
    input  ppr_pkg::ppr_lock_req_t lock_req,
    input  logic [15:0]            config_word_two,
    // Lock state.
    output logic                   map_write_lock,
    output logic                   single_session_lock_fuse,
    output logic                   unlock_open
);
    ppr_pkg::ppr_key_state_t state;
    ppr_pkg::ppr_key_state_t next_state;
    logic [2:0]              win_cnt;
    logic [2:0]              next_win_cnt;
    logic                    next_lock;
    logic                    fuse;
    logic                    next_fuse;
    logic                    fuse_taken;
    logic                    next_fuse_taken;
    logic                    frozen;

    // Once locked under the one-way fuse nothing but reset reopens it.
    assign frozen      = fuse && map_write_lock;
    assign unlock_open = (state == ppr_pkg::KS_OPEN);
    assign single_session_lock_fuse = fuse;

    // Key sequence, lock bit and fuse capture.
    always_comb begin
        next_state      = state;
        next_win_cnt    = win_cnt;
        next_lock       = map_write_lock;
        next_fuse       = fuse;
        next_fuse_taken = 1'b1;
        if (!fuse_taken) begin
            next_fuse = config_word_two[`PPR_ONE_WAY_BIT];
        end
        case (state)
            ppr_pkg::KS_IDLE: begin
                if (lock_req.key_wr && lock_req.key_data == `PPR_KEY_ONE && !frozen) begin
                    next_state = ppr_pkg::KS_ARMED;
                end
            end
            ppr_pkg::KS_ARMED: begin
                // The second key must follow on the very next cycle.
                if (lock_req.key_wr && lock_req.key_data == `PPR_KEY_TWO) begin
                    next_state   = ppr_pkg::KS_OPEN;
                    next_win_cnt = `PPR_UNLOCK_WIN;
                end else begin
                    next_state = ppr_pkg::KS_IDLE;
                end
            end
            ppr_pkg::KS_OPEN: begin
                next_win_cnt = win_cnt - 3'h1;
                if (lock_req.osc_wr || win_cnt == 3'h1) begin
                    next_state = ppr_pkg::KS_IDLE;
                end
            end
            default: begin
                next_state = ppr_pkg::KS_IDLE;
            end
        endcase
        if (lock_req.osc_wr) begin
            if (lock_req.osc_data[`PPR_LOCK_BIT]) begin
                next_lock = 1'b1;
            end else if (unlock_open && !frozen) begin
                next_lock = 1'b0;
            end
        end
    end

    // Registers; the fuse reads as one-way until it has been captured.
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state          <= ppr_pkg::KS_IDLE;
            win_cnt        <= 3'h0;
            map_write_lock <= `PPR_LOCK_RST;
            fuse           <= `PPR_FUSE_RST;
            fuse_taken     <= 1'b0;
        end else begin
            state          <= next_state;
            win_cnt        <= next_win_cnt;
            map_write_lock <= next_lock;
            fuse           <= next_fuse;
            fuse_taken     <= next_fuse_taken;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_one_way_hold: assert property (frozen |=> map_write_lock)
        else $error("Lock cleared while one-way fuse active.");
    a_clear_needs_key: assert property ($fell(map_write_lock) |-> $past(unlock_open) && !$past(fuse))
        else $error("Lock cleared without unlock window.");
endmodule : ppr_key_lock

// File: tb/ppr_pad_model.sv
// Pad ring and peripheral model that faces the remapping matrix.
`timescale 1ns/1ns
`include "ppr_remap_map.svh"
module ppr_pad_model (
    // Drive that the matrix puts on the pads.
    input  wire logic [`PPR_NUM_PINS-1:0]   pad_out,
    input  wire logic [`PPR_NUM_PINS-1:0]   pad_oe,
    // Level that outside parts put on pins the matrix leaves undriven.
    input  wire logic [`PPR_NUM_PINS-1:0]   ext_level,
    // Pattern that the digital peripherals show on their outputs.
    input  wire logic [`PPR_NUM_OUT_FN-1:0] out_pattern,
    // Toward the matrix.
    output logic [`PPR_NUM_PINS-1:0]        pad_in,
    output logic [`PPR_NUM_OUT_FN-1:0]      periph_out
);
    // A driven pin reads back its own drive; an undriven one shows the outside level.
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
    // Output code zero means no peripheral, so that line is held low.
    assign periph_out = {out_pattern[`PPR_NUM_OUT_FN-1:1], 1'b0};
endmodule : ppr_pad_model

// File: tb/ppr_remap_test.sv
// Self-checking testbench of the pin remapping matrix.
`timescale 1ns/1ns
`include "ppr_remap_map.svh"
module ppr_remap_test;
    // Signals around the matrix.
    logic                          sys_clk, resetn, map_rd_is_out, map_write_lock, single_session_lock_fuse;
    ppr_pkg::ppr_map_wr_t          map_wr;
    ppr_pkg::ppr_lock_req_t        lock_req;
    logic [3:0]                    map_rd_index;
    logic [15:0]                   map_rd_data, config_word_two;
    logic [`PPR_NUM_PINS-1:0]      pad_in, dir, port_out, fixed_oe, fixed_out, special_oe, special_out;
    logic [`PPR_NUM_PINS-1:0]      analog_en, pad_out, pad_oe, ext_level;
    logic [`PPR_NUM_OUT_FN-1:0]    periph_out, out_pattern;
    logic [`PPR_NUM_IN_FN-1:0]     periph_in;
    int                            fail_count, n_tests;

    ppr_remap dut_u (.sys_clk(sys_clk), .resetn(resetn), .map_wr(map_wr), .map_rd_is_out(map_rd_is_out),
        .map_rd_index(map_rd_index), .map_rd_data(map_rd_data), .lock_req(lock_req),
        .config_word_two(config_word_two), .map_write_lock(map_write_lock),
        .single_session_lock_fuse(single_session_lock_fuse), .pad_in(pad_in), .pin_direction_bit(dir),
        .port_out(port_out), .fixed_oe(fixed_oe), .fixed_out(fixed_out), .special_oe(special_oe),
        .special_out(special_out), .analog_en(analog_en), .pad_out(pad_out), .pad_oe(pad_oe),
        .periph_out(periph_out), .periph_in(periph_in));

    ppr_pad_model pad_u (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level),
        .out_pattern(out_pattern), .pad_in(pad_in), .periph_out(periph_out));

    // Free-running system clock at 100 MHz.
    always #5 sys_clk = ~sys_clk;

    // Comparison shared by every scenario.
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Moves to the n-th rising edge; inputs are driven there by non-blocking assignment,
    // and registered outputs read there still show what the edge before left.
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : step

    // Reset of four cycles; the fuse word is set first because it is sampled on release.
    task automatic do_reset(input logic fuse);
        config_word_two <= {11'h000, fuse, 4'h0};
        resetn          <= 1'b0;
        step(4);
        resetn          <= 1'b1;
        step(1);
    endtask : do_reset

    // One write pulse into a mapping register, then idle cycles; read-back follows the
    // written register so that the design's own write check sees its image.
    task automatic map_write(input logic is_out, input logic [3:0] idx, input logic [15:0] data);
        map_wr        <= '{wr: 1'b1, is_out: is_out, index: idx, data: data};
        map_rd_is_out <= is_out;
        map_rd_index  <= idx;
        step(1);
        map_wr.wr <= 1'b0;
        step(3);
    endtask : map_write

    // Reads a mapping register back and compares its image.
    task automatic read_check(input string what, input logic is_out, input logic [3:0] idx,
                              input logic [15:0] exp);
        map_rd_is_out <= is_out;
        map_rd_index  <= idx;
        step(2);
        check(what, {16'h0000, map_rd_data}, {16'h0000, exp});
    endtask : read_check

    // Writes the oscillator control byte that holds the lock bit.
    task automatic osc_write(input logic [7:0] data);
        lock_req <= '{osc_wr: 1'b1, osc_data: data, key_wr: 1'b0, key_data: 8'h00};
        step(1);
        lock_req <= '0;
        step(2);
    endtask : osc_write

    // Two keys on consecutive edges, then a lock clear inside the window.
    task automatic unlock_seq;
        lock_req <= '{osc_wr: 1'b0, osc_data: 8'h00, key_wr: 1'b1, key_data: `PPR_KEY_ONE};
        step(1);
        lock_req.key_data <= `PPR_KEY_TWO;
        step(1);
        lock_req <= '{osc_wr: 1'b1, osc_data: 8'h00, key_wr: 1'b0, key_data: 8'h00};
        step(1);
        lock_req <= '0;
        step(2);
    endtask : unlock_seq

    // State straight out of reset with the fuse unprogrammed.
    task automatic t_reset;
        do_reset(1'b1);
        step(2);
        check("pad_oe", {6'h00, pad_oe}, {6'h00, ~dir});
        check("pad_out", {6'h00, pad_out}, 32'h0000_0000);
        check("periph_in", {4'h0, periph_in}, 32'h0000_0000);
        check("lock", {31'h0, map_write_lock}, 32'h0);
        check("fuse", {31'h0, single_session_lock_fuse}, 32'h1);
        read_check("in_reg0", 1'b0, 4'h0, 16'h1f1f);
        read_check("out_reg12", 1'b1, 4'hc, 16'h0000);
    endtask : t_reset

    // Output codes against special, fixed and port drive on pins 0 to 3.
    task automatic t_outputs;
        dir         <= 26'h3ff_fff7;
        port_out    <= 26'h000_0008;
        fixed_oe    <= 26'h000_0004;
        fixed_out   <= 26'h000_0004;
        special_oe  <= 26'h000_0001;
        out_pattern <= 32'h0000_0200;
        map_write(1'b1, 4'h0, 16'h0909);
        map_write(1'b1, 4'h1, 16'h0707);
        check("oe_0_3", {28'h0, pad_oe[3:0]}, 32'hf);
        check("out_0_3", {28'h0, pad_out[3:0]}, 32'h2);
        read_check("out_reg1", 1'b1, 4'h1, 16'h0707);
        map_write(1'b1, 4'h0, 16'h0000);
        check("oe_code0", {28'h0, pad_oe[3:0]}, 32'hd);
    endtask : t_outputs

    // Input selection, analog masking and a selection past the last pin.
    task automatic t_inputs;
        ext_level   <= 26'h3ff_ffff;
        out_pattern <= 32'h0000_0080;
        map_write(1'b0, 4'h0, 16'h1905);
        map_write(1'b0, 4'h1, 16'h031a);
        check("periph_in", {28'h0, periph_in[3:0]}, 32'hb);
        check("oe_5_25", {30'h0, pad_oe[25], pad_oe[5]}, 32'h0);
        analog_en <= 26'h000_0020;
        step(2);
        check("analog_in", {28'h0, periph_in[3:0]}, 32'ha);
        analog_en <= '0;
        map_write(1'b0, 4'he, 16'h0101);
        read_check("in_reg14", 1'b0, 4'he, 16'h0000);
    endtask : t_inputs

    // Lock with the one-way fuse: no clearing except by reset.
    task automatic t_lock_one_way;
        osc_write(8'h40);
        check("lock_set", {31'h0, map_write_lock}, 32'h1);
        map_write(1'b0, 4'h0, 16'h0000);
        read_check("locked_reg", 1'b0, 4'h0, 16'h1905);
        unlock_seq();
        check("one_way", {31'h0, map_write_lock}, 32'h1);
        do_reset(1'b1);
        check("reset_clr", {31'h0, map_write_lock}, 32'h0);
        read_check("after_rst", 1'b0, 4'h0, 16'h1f1f);
    endtask : t_lock_one_way

    // Programmed fuse: lock cleared only by the key sequence, as often as wanted.
    task automatic t_lock_multi;
        do_reset(1'b0);
        step(1);
        check("fuse_prog", {31'h0, single_session_lock_fuse}, 32'h0);
        repeat (2) begin
            osc_write(8'h40);
            osc_write(8'h00);
            check("no_key", {31'h0, map_write_lock}, 32'h1);
            unlock_seq();
            check("key_clr", {31'h0, map_write_lock}, 32'h0);
        end
        map_write(1'b0, 4'h3, 16'h0402);
        read_check("reopened", 1'b0, 4'h3, 16'h0402);
    endtask : t_lock_multi

    // Prints the counts and the verdict, then stops the run.
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done

    // Main sequence; every input gets its value at time zero.
    initial begin
        sys_clk = 1'b0;
        fail_count = 0;
        n_tests = 0;
        map_wr <= '0;
        lock_req <= '0;
        map_rd_is_out <= 1'b0;
        map_rd_index <= 4'h0;
        dir <= 26'h155_5555;
        {port_out, fixed_oe, fixed_out, special_oe, special_out, analog_en} <= '0;
        ext_level <= 26'h2aa_aaaa;
        out_pattern <= '0;
        t_reset();
        t_outputs();
        t_inputs();
        t_lock_one_way();
        t_lock_multi();
        test_done();
    end

    // Watchdog well beyond the hundred or so cycles the scenarios need.
    initial begin
        #200000;
        fail_count++;
        test_done();
    end
endmodule : ppr_remap_test
